/* sle_event_manager.sv */
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
module sle_event_manager (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Peripheral events and direct top-level lines
  input sle_pkg::sle_periph_evt_s periph_evt_in,
  input wire logic [16:0] line_req_in,
  // NMI sources
  input wire logic xtal_ok_in,
  input wire logic wdog_active_in,
  input wire logic wdog_lowwater_in,
  // Bus access under fault check
  input sle_pkg::sle_bus_access_s bus_access_in,
  // Requests and status
  output logic [16:0] top_irq_out,
  output logic nmi_out,
  output logic clk_sel_rc_out,
  output logic bus_fault_out,
  output logic hard_fault_out
);

  logic aw_got, w_got;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic [31:0] conv_flags, conv_mask, ser1_flags, ser1_mask, ser2_flags, ser2_mask;
  logic [31:0] tmr1_flags, tmr1_mask, tmr2_flags, tmr2_mask;
  logic [31:0] conv_evt, ser1_evt, ser2_evt, tmr1_evt, tmr2_evt;
  logic [1:0] nmi_flags;
  logic [16:0] missed, miss_evt, pend_latch, top_enable, level_req, pending;
  logic [3:0] fault_cause, next_fault, new_cause;
  logic second_fault;
  logic xtal_meta, xtal_ok_s, on_xtal, fail_pend;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] strb);
    be_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction
  // Written one-bits landing on a given offset this cycle
  function automatic logic [31:0] wr_bits(input logic [7:0] off);
    wr_bits = (wr_fire && wr_addr == off) ? (wr_data & be_mask(wr_strb)) : sle_pkg::ZERO32;
  endfunction
  // Plain read-write merge under the byte strobes
  function automatic logic [31:0] rw_merge(input logic [31:0] cur, input logic [7:0] off);
    logic [31:0] m;
    m = be_mask(wr_strb);
    rw_merge = (wr_fire && wr_addr == off) ? ((cur & ~m) | (wr_data & m)) : cur;
  endfunction
  // Set wins over the write-one clear
  function automatic logic [31:0] w1c(input logic [31:0] cur, input logic [31:0] clr,
                                      input logic [31:0] evt);
    w1c = (cur & ~clr) | evt;
  endfunction
  // Word-aligned and inside the map
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= sle_pkg::OFF_CLK_CTRL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  // Address and data taken in either order, answer after both
  assign wr_fire = aw_got & w_got & ~s_axi_bvalid_out;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= sle_pkg::ZERO32;
      wr_strb <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= sle_pkg::RESP_OKAY;
    end else begin
      if (!aw_got && !s_axi_bvalid_out) begin
        s_axi_awready_out <= ~(s_axi_awvalid_in & s_axi_awready_out);
      end
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got <= 1'b1;
        wr_addr <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (!w_got && !s_axi_bvalid_out) begin
        s_axi_wready_out <= ~(s_axi_wvalid_in & s_axi_wready_out);
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got <= 1'b1;
        wr_data <= s_axi_wdata_in;
        wr_strb <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= is_mapped(wr_addr) ? sle_pkg::RESP_OKAY : sle_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  // Read is side-effect free; one cycle from address to data
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= sle_pkg::ZERO32;
      s_axi_rresp_out <= sle_pkg::RESP_OKAY;
    end else if (s_axi_rvalid_out) begin
      s_axi_arready_out <= 1'b0;
      if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= is_mapped(s_axi_araddr_in) ? sle_pkg::RESP_OKAY : sle_pkg::RESP_SLVERR;
      case (s_axi_araddr_in)
        sle_pkg::OFF_CONV_FLAGS: s_axi_rdata_out <= conv_flags;
        sle_pkg::OFF_CONV_MASK: s_axi_rdata_out <= conv_mask;
        sle_pkg::OFF_SER1_FLAGS: s_axi_rdata_out <= ser1_flags;
        sle_pkg::OFF_SER1_MASK: s_axi_rdata_out <= ser1_mask;
        sle_pkg::OFF_SER2_FLAGS: s_axi_rdata_out <= ser2_flags;
        sle_pkg::OFF_SER2_MASK: s_axi_rdata_out <= ser2_mask;
        sle_pkg::OFF_TMR1_FLAGS: s_axi_rdata_out <= tmr1_flags;
        sle_pkg::OFF_TMR1_MASK: s_axi_rdata_out <= tmr1_mask;
        sle_pkg::OFF_TMR2_FLAGS: s_axi_rdata_out <= tmr2_flags;
        sle_pkg::OFF_TMR2_MASK: s_axi_rdata_out <= tmr2_mask;
        sle_pkg::OFF_NMI_FLAGS: s_axi_rdata_out <= 32'(nmi_flags);
        sle_pkg::OFF_MISSED: s_axi_rdata_out <= 32'(missed);
        sle_pkg::OFF_FAULT_CAUSE: s_axi_rdata_out <= 32'(fault_cause);
        sle_pkg::OFF_PEND_SET: s_axi_rdata_out <= 32'(pending);
        sle_pkg::OFF_ENABLE_SET: s_axi_rdata_out <= 32'(top_enable);
        sle_pkg::OFF_CLK_CTRL: s_axi_rdata_out <= 32'(on_xtal);
        default: s_axi_rdata_out <= sle_pkg::ZERO32;
      endcase
    end else begin
      s_axi_arready_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second-level flags and masks

  // Events widened; unused timer bit 5 never sets
  assign conv_evt = 32'(periph_evt_in.conv) & sle_pkg::FIELD_CONV;
  assign ser1_evt = 32'(periph_evt_in.ser1) & sle_pkg::FIELD_SER1;
  assign ser2_evt = 32'(periph_evt_in.ser2) & sle_pkg::FIELD_SER2;
  assign tmr1_evt = 32'(periph_evt_in.tmr1) & sle_pkg::FIELD_TMR;
  assign tmr2_evt = 32'(periph_evt_in.tmr2) & sle_pkg::FIELD_TMR;
  // Flags always live, whatever the masks say
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      conv_flags <= sle_pkg::ZERO32;
      ser1_flags <= sle_pkg::ZERO32;
      ser2_flags <= sle_pkg::ZERO32;
      tmr1_flags <= sle_pkg::ZERO32;
      tmr2_flags <= sle_pkg::ZERO32;
    end else begin
      conv_flags <= w1c(conv_flags, wr_bits(sle_pkg::OFF_CONV_FLAGS), conv_evt);
      ser1_flags <= w1c(ser1_flags, wr_bits(sle_pkg::OFF_SER1_FLAGS), ser1_evt);
      ser2_flags <= w1c(ser2_flags, wr_bits(sle_pkg::OFF_SER2_FLAGS), ser2_evt);
      tmr1_flags <= w1c(tmr1_flags, wr_bits(sle_pkg::OFF_TMR1_FLAGS), tmr1_evt);
      tmr2_flags <= w1c(tmr2_flags, wr_bits(sle_pkg::OFF_TMR2_FLAGS), tmr2_evt);
    end
  end
  // Masks are plain read-write
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      conv_mask <= sle_pkg::ZERO32;
      ser1_mask <= sle_pkg::ZERO32;
      ser2_mask <= sle_pkg::ZERO32;
      tmr1_mask <= sle_pkg::ZERO32;
      tmr2_mask <= sle_pkg::ZERO32;
    end else begin
      conv_mask <= rw_merge(conv_mask, sle_pkg::OFF_CONV_MASK) & sle_pkg::FIELD_CONV;
      ser1_mask <= rw_merge(ser1_mask, sle_pkg::OFF_SER1_MASK) & sle_pkg::FIELD_SER1;
      ser2_mask <= rw_merge(ser2_mask, sle_pkg::OFF_SER2_MASK) & sle_pkg::FIELD_SER2;
      tmr1_mask <= rw_merge(tmr1_mask, sle_pkg::OFF_TMR1_MASK) & sle_pkg::FIELD_TMR;
      tmr2_mask <= rw_merge(tmr2_mask, sle_pkg::OFF_TMR2_MASK) & sle_pkg::FIELD_TMR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Missed events and top-level requests

  // No counting: an enabled repeat on a set flag only marks missed
  always_comb begin
    miss_evt = 17'h00000;
    miss_evt[sle_pkg::TOP_CONV] = |(conv_evt & conv_flags & conv_mask);
    miss_evt[sle_pkg::TOP_SERIAL_ONE] = |(ser1_evt & ser1_flags & ser1_mask);
    miss_evt[sle_pkg::TOP_SERIAL_TWO] = |(ser2_evt & ser2_flags & ser2_mask);
    miss_evt[sle_pkg::TOP_TIMER_ONE] = |(tmr1_evt & tmr1_flags & tmr1_mask);
    miss_evt[sle_pkg::TOP_TIMER_TWO] = |(tmr2_evt & tmr2_flags & tmr2_mask);
  end
  // Level requests; lines without a second level pass straight in
  always_comb begin
    level_req = line_req_in & sle_pkg::LINE_ONLY_TOP;
    level_req[sle_pkg::TOP_CONV] = |(conv_flags & conv_mask);
    level_req[sle_pkg::TOP_SERIAL_ONE] = |(ser1_flags & ser1_mask);
    level_req[sle_pkg::TOP_SERIAL_TWO] = |(ser2_flags & ser2_mask);
    level_req[sle_pkg::TOP_TIMER_ONE] = |(tmr1_flags & tmr1_mask);
    level_req[sle_pkg::TOP_TIMER_TWO] = |(tmr2_flags & tmr2_mask);
  end
  // A pending clear cannot beat a level still held below
  assign pending = pend_latch | level_req;
  // Missed marks, cleared by writing one
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      missed <= 17'h00000;
    end else begin
      missed <= 17'(w1c(32'(missed), wr_bits(sle_pkg::OFF_MISSED), 32'(miss_evt)));
    end
  end

  // Pending latch and enable mask, both set and cleared by strobes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pend_latch <= 17'h00000;
      top_enable <= 17'h00000;
      top_irq_out <= 17'h00000;
    end else begin
      pend_latch <= (pend_latch & ~17'(wr_bits(sle_pkg::OFF_PEND_CLR)))
                    | 17'(wr_bits(sle_pkg::OFF_PEND_SET));
      top_enable <= (top_enable & ~17'(wr_bits(sle_pkg::OFF_ENABLE_CLR)))
                    | 17'(wr_bits(sle_pkg::OFF_ENABLE_SET));
      top_irq_out <= pending & top_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal supervision and NMI

  // Pin passes two flops before use
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      xtal_meta <= 1'b0;
      xtal_ok_s <= 1'b0;
    end else begin
      xtal_meta <= xtal_ok_in;
      xtal_ok_s <= xtal_meta;
    end
  end
  // Switch to RC first; the flag follows one cycle later
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      on_xtal <= 1'b0;
      fail_pend <= 1'b0;
      clk_sel_rc_out <= 1'b1;
    end else begin
      fail_pend <= 1'b0;
      if (on_xtal && !xtal_ok_s) begin
        on_xtal <= 1'b0;
        fail_pend <= 1'b1;
        clk_sel_rc_out <= 1'b1;
      end else if (wr_fire && wr_addr == sle_pkg::OFF_CLK_CTRL && wr_strb[0]) begin
        // Crystal only accepted while it is seen running
        on_xtal <= wr_data[sle_pkg::CLK_USE_XTAL] & xtal_ok_s;
        clk_sel_rc_out <= ~(wr_data[sle_pkg::CLK_USE_XTAL] & xtal_ok_s);
      end
    end
  end
  // Non-maskable: no enable stands between these flags and the output
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      nmi_flags <= 2'h0;
      nmi_out <= 1'b0;
    end else begin
      nmi_flags <= 2'(w1c(32'(nmi_flags), wr_bits(sle_pkg::OFF_NMI_FLAGS),
                         32'({fail_pend, wdog_active_in & wdog_lowwater_in})));
      nmi_out <= |nmi_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus fault causes

  always_comb begin
    new_cause = 4'h0;
    if (bus_access_in.valid) begin
      new_cause[sle_pkg::FAULT_BAD_WIDTH] = (bus_access_in.apb_reg && bus_access_in.size != sle_pkg::SIZE_WORD)
        || (bus_access_in.size == sle_pkg::SIZE_WORD && bus_access_in.addr_lo != 2'h0);
      new_cause[sle_pkg::FAULT_PROTECT] = bus_access_in.user_mode && bus_access_in.write
        && bus_access_in.sys_target;
      new_cause[sle_pkg::FAULT_RESERVED] = bus_access_in.beyond_reg || bus_access_in.beyond_mem;
    end
  end

  // Second fault escalates; a process, since the clear reads bus state inside a function
  always_comb begin
    second_fault = (|new_cause) && (|fault_cause[2:0]);
    next_fault = 4'(w1c(32'(fault_cause), wr_bits(sle_pkg::OFF_FAULT_CAUSE), 32'(new_cause)))
                 | (4'(second_fault) << sle_pkg::FAULT_MISSED);
  end

  // Causes held until written one
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fault_cause <= 4'h0;
      bus_fault_out <= 1'b0;
      hard_fault_out <= 1'b0;
    end else begin
      fault_cause <= next_fault & sle_pkg::FIELD_FAULT[3:0];
      bus_fault_out <= |next_fault[2:0];
      hard_fault_out <= second_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence xtal_lost_s;
    on_xtal && !xtal_ok_s;
  endsequence
  sequence rc_then_flag_s;
    clk_sel_rc_out && !nmi_flags[sle_pkg::NMI_XTAL] ##1 nmi_flags[sle_pkg::NMI_XTAL];
  endsequence
  xtal_order_a: assert property (xtal_lost_s |=> rc_then_flag_s) else $error("crystal flag order wrong");
  nmi_drive_a: assert property (nmi_flags != 2'h0 |=> nmi_out) else $error("nmi not raised");
  wdog_flag_a: assert property (wdog_active_in && wdog_lowwater_in |=> nmi_flags[sle_pkg::NMI_WDOG])
    else $error("watchdog flag missing");
  flag_set_a: assert property (conv_evt != 0 |=> (conv_flags & $past(conv_evt)) == $past(conv_evt))
    else $error("converter event lost");
  flag_clear_a: assert property (wr_fire && wr_addr == sle_pkg::OFF_TMR1_FLAGS && wr_strb == 4'hf
    && tmr1_evt == 0 |=> (tmr1_flags & $past(wr_data)) == 0) else $error("flag not cleared");
  req_level_a: assert property (|(ser1_flags & ser1_mask) && top_enable[sle_pkg::TOP_SERIAL_ONE]
    |=> top_irq_out[sle_pkg::TOP_SERIAL_ONE]) else $error("serial request dropped");
  mask_late_a: assert property ($rose(|(tmr2_flags & tmr2_mask)) && top_enable[sle_pkg::TOP_TIMER_TWO]
    |=> top_irq_out[sle_pkg::TOP_TIMER_TWO]) else $error("late mask not propagated");
  miss_mark_a: assert property (miss_evt[sle_pkg::TOP_CONV] |=> missed[sle_pkg::TOP_CONV])
    else $error("missed bit not set");
  width_fault_a: assert property (bus_access_in.valid && bus_access_in.apb_reg
    && bus_access_in.size != sle_pkg::SIZE_WORD |=> fault_cause[sle_pkg::FAULT_BAD_WIDTH] ##0 bus_fault_out)
    else $error("bad width not flagged");
  second_fault_a: assert property (second_fault |=> hard_fault_out && fault_cause[sle_pkg::FAULT_MISSED])
    else $error("second fault not escalated");
  pend_gate_a: assert property (!top_enable[sle_pkg::TOP_CONV] |=> !top_irq_out[sle_pkg::TOP_CONV])
    else $error("request passed disabled gate");
endmodule

/* sle_evt_src.sv */
`timescale 1ns/1ns
// Peripheral event sources, one-cycle strobes on command
module sle_evt_src (
  // Clock and command
  input wire logic clk_in,
  input wire logic go_in,
  input sle_pkg::sle_periph_evt_s req_in,
  // Strobes toward the block
  output sle_pkg::sle_periph_evt_s evt_out
);
  // Strobes follow the command each cycle, so a held command repeats the event every cycle
  always_ff @(posedge clk_in) begin
    evt_out <= go_in ? req_in : '0;
  end
endmodule

/* sle_pkg.sv */
package sle_pkg;
  // Register byte offsets on the AXI4-Lite port
  localparam logic [7:0] OFF_CONV_FLAGS = 8'h00;
  localparam logic [7:0] OFF_CONV_MASK = 8'h04;
  localparam logic [7:0] OFF_SER1_FLAGS = 8'h08;
  localparam logic [7:0] OFF_SER1_MASK = 8'h0c;
  localparam logic [7:0] OFF_SER2_FLAGS = 8'h10;
  localparam logic [7:0] OFF_SER2_MASK = 8'h14;
  localparam logic [7:0] OFF_TMR1_FLAGS = 8'h18;
  localparam logic [7:0] OFF_TMR1_MASK = 8'h1c;
  localparam logic [7:0] OFF_TMR2_FLAGS = 8'h20;
  localparam logic [7:0] OFF_TMR2_MASK = 8'h24;
  localparam logic [7:0] OFF_NMI_FLAGS = 8'h28;
  localparam logic [7:0] OFF_MISSED = 8'h2c;
  localparam logic [7:0] OFF_FAULT_CAUSE = 8'h30;
  localparam logic [7:0] OFF_PEND_SET = 8'h34;
  localparam logic [7:0] OFF_PEND_CLR = 8'h38;
  localparam logic [7:0] OFF_ENABLE_SET = 8'h3c;
  localparam logic [7:0] OFF_ENABLE_CLR = 8'h40;
  localparam logic [7:0] OFF_CLK_CTRL = 8'h44;
  // Implemented bits of each register
  localparam logic [31:0] FIELD_CONV = 32'h0000001f;
  localparam logic [31:0] FIELD_SER1 = 32'h00007fff;
  localparam logic [31:0] FIELD_SER2 = 32'h00001fff;
  localparam logic [31:0] FIELD_TMR = 32'h0000005f;
  localparam logic [31:0] FIELD_NMI = 32'h00000003;
  localparam logic [31:0] FIELD_TOP = 32'h0001ffff;
  localparam logic [31:0] FIELD_FAULT = 32'h0000000f;
  localparam logic [16:0] LINE_ONLY_TOP = 17'h1f79c;
  localparam logic [31:0] ZERO32 = 32'h00000000;
  // Top-level request positions
  localparam int TOP_TIMER_ONE = 0;
  localparam int TOP_TIMER_TWO = 1;
  localparam int TOP_SERIAL_ONE = 5;
  localparam int TOP_SERIAL_TWO = 6;
  localparam int TOP_CONV = 11;
  // NMI and fault cause bit positions
  localparam int NMI_WDOG = 0;
  localparam int NMI_XTAL = 1;
  localparam int FAULT_BAD_WIDTH = 0;
  localparam int FAULT_PROTECT = 1;
  localparam int FAULT_RESERVED = 2;
  localparam int FAULT_MISSED = 3;
  localparam int CLK_USE_XTAL = 0;
  // Bus encodings
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event strobes from the peripherals, one-cycle pulses
  typedef struct packed {
    logic [4:0] conv;
    logic [14:0] ser1;
    logic [12:0] ser2;
    logic [6:0] tmr1;
    logic [6:0] tmr2;
  } sle_periph_evt_s;

  // One bus access under check; size 0 byte, 1 half, 2 word
  typedef struct packed {
    logic valid;
    logic [1:0] size;
    logic [1:0] addr_lo;
    logic apb_reg;
    logic user_mode;
    logic write;
    logic sys_target;
    logic beyond_reg;
    logic beyond_mem;
  } sle_bus_access_s;
endpackage

/* tb_second_level_event_manager.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_second_level_event_manager;
  logic clk_in = 0, srst_in = 1, go = 0, xok = 1, wact = 0, wlow = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, nmi, rc, bf, hf;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, resp;
  logic [16:0] irq, lines = '0;
  sle_pkg::sle_periph_evt_s req = '0, evt;
  sle_pkg::sle_bus_access_s acc = '0;
  int fails = 0, n_tests = 0, hf_n = 0;
  ////////////////////////////////////////////////////////////////
  // Clock, and a count of hard fault pulses since they last one cycle
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) if (hf === 1'b1) hf_n++;
  sle_evt_src u_sle_evt_src (.clk_in(clk_in), .go_in(go), .req_in(req), .evt_out(evt));
  sle_event_manager u_sle_event_manager (
    .clk_in(clk_in), .srst_in(srst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .periph_evt_in(evt), .line_req_in(lines), .xtal_ok_in(xok), .wdog_active_in(wact),
    .wdog_lowwater_in(wlow), .bus_access_in(acc), .top_irq_out(irq), .nmi_out(nmi),
    .clk_sel_rc_out(rc), .bus_fault_out(bf), .hard_fault_out(hf));
  ////////////////////////////////////////////////////////////////
  // Bus write; each valid drops only once its ready was seen high
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    forever begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    resp = bresp;
  endtask
  // Bus read, then compare the returned word
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    forever begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    d = rdata;
    resp = rresp;
    `CHK(d, e)
  endtask
  // One strobe from the sources, then time for the flag to land
  task automatic ev(input sle_pkg::sle_periph_evt_s r);
    @(posedge clk_in);
    req <= r;
    go <= 1;
    @(posedge clk_in);
    go <= 0;
    repeat (3) @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h2c, 32'h0);
    rdc(8'h30, 32'h0);
    wr(8'h80, 32'h1);
    `CHK(resp, sle_pkg::RESP_SLVERR)
    rdc(8'h80, 32'h0);
    `CHK(resp, sle_pkg::RESP_SLVERR)
  endtask
  task automatic t_events;
    ev('{conv: 5'h10, tmr1: 7'h40, default: '0});
    rdc(8'h00, 32'h10);
    `CHK(irq, 17'h0)
    wr(8'h3c, 32'h801);
    wr(8'h04, 32'h10);
    wr(8'h1c, 32'h40);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 17'h00801)
    wr(8'h00, 32'h0);
    rdc(8'h00, 32'h10);
    ev('{conv: 5'h10, default: '0});
    rdc(8'h2c, 32'h800);
    wr(8'h2c, 32'h800);
    rdc(8'h2c, 32'h0);
    wr(8'h00, 32'h10);
    wr(8'h18, 32'h40);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 17'h0)
  endtask
  // Serial one and timer two, split clears, the pending latch and a plain line
  task automatic t_levels;
    wr(8'h3c, 32'h22);
    ev('{ser1: 15'h4001, tmr2: 7'h01, default: '0});
    `CHK(irq, 17'h0)
    wr(8'h0c, 32'h4001);
    wr(8'h24, 32'h1);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 17'h00022)
    wr(8'h08, 32'h4000);
    rdc(8'h08, 32'h1);
    `CHK(irq, 17'h00022)
    wr(8'h08, 32'h1);
    wr(8'h20, 32'h1);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 17'h0)
    wr(8'h34, 32'h10000);
    rdc(8'h34, 32'h10000);
    `CHK(irq, 17'h0)
    wr(8'h3c, 32'h10000);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 17'h10000)
    wr(8'h38, 32'h10000);
    @(posedge clk_in);
    lines <= 17'h01000;
    repeat (3) @(posedge clk_in);
    `CHK(irq, 17'h0)
    wr(8'h3c, 32'h1000);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 17'h01000)
    lines <= 17'h0;
  endtask
  task automatic t_nmi;
    wr(8'h44, 32'h1);
    rdc(8'h44, 32'h1);
    `CHK({rc, nmi}, 2'b00)
    @(posedge clk_in);
    xok <= 0;
    repeat (6) @(posedge clk_in);
    `CHK({rc, nmi}, 2'b11)
    rdc(8'h28, 32'h2);
    wr(8'h28, 32'h2);
    @(posedge clk_in);
    wact <= 1;
    wlow <= 1;
    @(posedge clk_in);
    wlow <= 0;
    repeat (3) @(posedge clk_in);
    rdc(8'h28, 32'h1);
    `CHK(nmi, 1'b1)
  endtask
  // Unaligned user write past the last register, then a byte access
  task automatic t_fault;
    @(posedge clk_in);
    acc <= '{1'b1, 2'h2, 2'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    @(posedge clk_in);
    acc <= '0;
    repeat (2) @(posedge clk_in);
    rdc(8'h30, 32'h7);
    `CHK(bf, 1'b1)
    @(posedge clk_in);
    acc <= '{1'b1, 2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    @(posedge clk_in);
    acc <= '0;
    repeat (2) @(posedge clk_in);
    rdc(8'h30, 32'hf);
    `CHK(hf_n, 1)
    wr(8'h30, 32'hf);
    rdc(8'h30, 32'h0);
    `CHK(bf, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 0;
    t_reset;
    t_events;
    t_levels;
    t_nmi;
    t_fault;
    tally_and_finish;
  end
  // Watchdog at 20000 cycles, well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end
endmodule
